// File: include/switch_ctl_pkg.sv
// constants, register map and state encodings of the switch control block
// assumes one 250 MHz clock to which the serial and pin inputs are synchronous
package switch_ctl_pkg;

   // ************************************************************
   // serial address and register map
   // ************************************************************
   localparam logic [3:0] DEV_ADDR_HI = 4'h9;
   localparam logic [7:0] OFS_FAST_MODE = 8'h00;
   localparam logic [7:0] OFS_SIDE_MODE = 8'h01;
   localparam logic [7:0] OFS_RX_SET = 8'h10;
   localparam logic [7:0] OFS_TERM_PULSE = 8'h11;
   localparam logic [7:0] RST_FAST_MODE = 8'h40;
   localparam logic [7:0] RST_SIDE_MODE = 8'h40;
   localparam logic [7:0] RST_RX_SET = 8'h01;
   localparam logic [7:0] RST_TERM_PULSE = 8'h00;
   localparam logic [7:0] RST_PIN_GRP = 8'h00;
   localparam logic [7:0] MASK_MODE = 8'h7f;
   localparam logic [7:0] MASK_RX = 8'h01;
   localparam logic [7:0] MASK_TERM = 8'hff;
   localparam int SW_ON_BIT = 6;
   localparam int MODE_MSB = 5;
   localparam int MODE_LSB = 4;
   localparam int SRC_MSB = 3;
   localparam logic [1:0] MODE_QUAD = 2'h0;
   localparam logic [1:0] MODE_BAD = 2'h3;
   localparam logic [3:0] BIT_LAST = 4'h8;

   // ************************************************************
   // pin group layout and values shown while the other path rules
   // ************************************************************
   localparam int PIN_ON = 0;
   localparam int PIN_SRC_LSB = 1;
   localparam int PIN_EQ = 3;
   localparam int PIN_PRE_LSB = 4;
   localparam int PIN_OTO = 6;
   localparam int PIN_OCL = 7;
   localparam logic SER_EQ = 1'b0;
   localparam logic [1:0] SER_PRE = 2'h0;
   localparam logic SER_OTO = 1'b1;
   localparam logic SER_OCL = 1'b1;
   localparam logic PIN_RX_TERM = 1'b1;

   // ************************************************************
   // update delay channels
   // ************************************************************
   localparam int NUM_CH = 5;
   localparam int CH_FAST = 0;
   localparam int CH_SIDE = 1;
   localparam int CH_RX = 2;
   localparam int CH_TERM = 3;
   localparam int CH_PIN = 4;
   localparam int CLK_NS = 4;
   localparam int DLY_NS [NUM_CH] = '{100, 100, 200, 200, 100};
   function automatic int ns_to_cyc(input int ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction
   localparam int DLY_CYC [NUM_CH] = '{ns_to_cyc(DLY_NS[0]),
      ns_to_cyc(DLY_NS[1]), ns_to_cyc(DLY_NS[2]),
      ns_to_cyc(DLY_NS[3]), ns_to_cyc(DLY_NS[4])};
   localparam logic [7:0] CH_RST [NUM_CH] = '{RST_FAST_MODE,
      RST_SIDE_MODE, RST_RX_SET, RST_TERM_PULSE, RST_PIN_GRP};

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_ADDR_ACK = 4'h2,
      ST_REG = 4'h3,
      ST_REG_ACK = 4'h4,
      ST_WDATA = 4'h5,
      ST_WDATA_ACK = 4'h6,
      ST_RDATA = 4'h7,
      ST_RDATA_ACK = 4'h8
   } bus_state_e;

endpackage

// File: verilog/line_events.sv
// start, stop and clock edge detection on the two-wire serial lines
// assumes scl and sda already synchronous to clock_i
`timescale 1ns/10ps
module line_events (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_rise_o,
   output logic scl_fall_o,
   output logic start_o,
   output logic stop_o
);
   logic scl_ff;
   logic sda_ff;

   // idle level of both lines is high
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
      end else begin
         scl_ff <= scl_i;
         sda_ff <= sda_i;
      end
   end

   // sda moving while scl stays high marks start or stop
   assign scl_rise_o = scl_i & ~scl_ff;
   assign scl_fall_o = ~scl_i & scl_ff;
   assign start_o = scl_i & scl_ff & sda_ff & ~sda_i;
   assign stop_o = scl_i & scl_ff & ~sda_ff & sda_i;
endmodule

// File: verilog/update_window.sv
// one register's update delay window between written and applied value
// assumes one-cycle write strobes from the owning control path
`timescale 1ns/10ps
module update_window #(
   parameter logic [7:0] RST_VAL = 8'h00,
   parameter logic [15:0] DLY = 16'h0001
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic wr_i,
   input wire logic [7:0] wr_data_i,
   output logic [7:0] applied_o
);
   logic [15:0] cnt_ff;
   logic [7:0] held_ff;
   logic pend_ff;

   // an open window only records; its last cycle applies the newest value
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cnt_ff <= 16'h0000;
         held_ff <= RST_VAL;
         pend_ff <= 1'b0;
         applied_o <= RST_VAL;
      end else if (cnt_ff == 16'h0000) begin
         if (wr_i) begin
            applied_o <= wr_data_i;
            cnt_ff <= DLY;
         end
      end else if (cnt_ff == 16'h0001) begin
         cnt_ff <= 16'h0000;
         pend_ff <= 1'b0;
         if (wr_i) begin
            applied_o <= wr_data_i;
         end else if (pend_ff) begin
            applied_o <= held_ff;
         end
      end else begin
         cnt_ff <= cnt_ff - 16'h0001;
         if (wr_i) begin
            held_ff <= wr_data_i;
            pend_ff <= 1'b1;
         end
      end
   end

   win_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (cnt_ff > 16'h0001 && wr_i) |=> (cnt_ff == $past(cnt_ff) - 16'h0001)
      && (applied_o == $past(applied_o)))
      else $error("write restarted or leaked through an open window");
   win_open_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (cnt_ff == 16'h0000 && wr_i) |=> (applied_o == $past(wr_data_i))
      && (cnt_ff == DLY))
      else $error("write after expiry not applied at once");
endmodule

// File: verilog/switch_control_serial_port.sv
// serial slave register port and pin control path of the link switch
// assumes all pins synchronous to clock_i; sda is open drain, pulled up
`timescale 1ns/10ps
module switch_control_serial_port (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic addr_strap_bit0_i,
   input wire logic addr_strap_bit1_i,
   input wire logic addr_strap_bit2_i,
   input wire logic pin_ctl_on_i,
   input wire logic [1:0] pin_ctl_source_i,
   input wire logic pin_ctl_equalize_i,
   input wire logic [1:0] pin_ctl_emphasis_i,
   input wire logic pin_ctl_out_term_i,
   input wire logic pin_ctl_out_current_i,
   output logic serial_mode_o,
   output logic fast_switch_on_o,
   output logic fast_standby_o,
   output logic [1:0] fast_bundle_mode_o,
   output logic [3:0] fast_source_sel_o,
   output logic side_switch_on_o,
   output logic [1:0] side_bundle_mode_o,
   output logic [3:0] side_source_sel_o,
   output logic input_term_sel_o,
   output logic [7:0] term_pulse_sel_o,
   output logic equalize_o,
   output logic [1:0] emphasis_o,
   output logic out_term_o,
   output logic out_current_o
);
   import switch_ctl_pkg::*;

   bus_state_e state_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] rx_ff;
   logic [7:0] tx_ff;
   logic rw_ff;
   logic nack_ff;
   logic [7:0] ptr_ff;
   logic serial_mode_ff;
   logic [7:0] regs_ff [NUM_CH];
   logic [7:0] applied [NUM_CH];
   logic [NUM_CH-1:0] wr_pulse;
   logic [7:0] wr_data [NUM_CH];
   logic [7:0] pins_ff;
   logic pins_primed_ff;
   logic [7:0] pins_now;
   logic [6:0] my_addr;
   logic [7:0] rd_value;
   logic [7:0] merged;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic last_bit;
   logic data_done;
   logic addr_hit;
   logic pin_change;

   // ************************************************************
   // line events and address
   // ************************************************************
   line_events u_line (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .scl_rise_o(scl_rise),
      .scl_fall_o(scl_fall),
      .start_o(start_seen),
      .stop_o(stop_seen)
   );

   // fixed upper nibble, strap bits below
   assign my_addr = {DEV_ADDR_HI, addr_strap_bit2_i, addr_strap_bit1_i,
      addr_strap_bit0_i};
   assign last_bit = scl_fall && (bit_cnt_ff == BIT_LAST);
   assign addr_hit = (rx_ff[7:1] == my_addr);
   assign data_done = (state_ff == ST_WDATA) && last_bit;

   // ************************************************************
   // byte protocol state machine
   // ************************************************************
   // start always wins, so a repeated start reopens the address phase
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
         bit_cnt_ff <= 4'h0;
         rw_ff <= 1'b0;
         nack_ff <= 1'b0;
         tx_ff <= 8'h00;
      end else if (start_seen) begin
         state_ff <= ST_ADDR;
         bit_cnt_ff <= 4'h0;
      end else if (stop_seen) begin
         state_ff <= ST_IDLE;
      end else if (scl_rise) begin
         if (state_ff == ST_RDATA_ACK) begin
            nack_ff <= sda_i;
         end
         if (state_ff == ST_ADDR || state_ff == ST_REG ||
             state_ff == ST_WDATA) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
         end
      end else if (scl_fall) begin
         bit_cnt_ff <= 4'h0;
         case (state_ff)
            ST_ADDR: begin
               if (bit_cnt_ff != BIT_LAST) begin
                  bit_cnt_ff <= bit_cnt_ff;
               end else if (addr_hit) begin
                  state_ff <= ST_ADDR_ACK;
                  rw_ff <= rx_ff[0];
               end else begin
                  state_ff <= ST_IDLE;
               end
            end
            ST_ADDR_ACK: begin
               if (rw_ff) begin
                  state_ff <= ST_RDATA;
                  tx_ff <= rd_value;
               end else begin
                  state_ff <= ST_REG;
               end
            end
            ST_REG: begin
               if (bit_cnt_ff == BIT_LAST) begin
                  state_ff <= ST_REG_ACK;
               end else begin
                  bit_cnt_ff <= bit_cnt_ff;
               end
            end
            ST_REG_ACK: state_ff <= ST_WDATA;
            ST_WDATA: begin
               if (bit_cnt_ff == BIT_LAST) begin
                  state_ff <= ST_WDATA_ACK;
               end else begin
                  bit_cnt_ff <= bit_cnt_ff;
               end
            end
            // only one data byte per write; extra bytes are ignored
            ST_WDATA_ACK: state_ff <= ST_IDLE;
            ST_RDATA: begin
               if (bit_cnt_ff == 4'h7) begin
                  state_ff <= ST_RDATA_ACK;
               end else begin
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  tx_ff <= {tx_ff[6:0], 1'b0};
               end
            end
            ST_RDATA_ACK: begin
               if (nack_ff) begin
                  state_ff <= ST_IDLE;
               end else begin
                  state_ff <= ST_RDATA;
                  tx_ff <= rd_value;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // receive shifter samples sda on each rising scl
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rx_ff <= 8'h00;
      end else if (scl_rise) begin
         rx_ff <= {rx_ff[6:0], sda_i};
      end
   end

   // pointer only moves on a register address byte, never on a restart
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ptr_ff <= 8'h00;
      end else if (!start_seen && state_ff == ST_REG && last_bit) begin
         ptr_ff <= rx_ff;
      end
   end

   // drive low for acks and for zero data bits; changes while scl is low
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sda_oe_o <= 1'b0;
      end else begin
         sda_oe_o <= (state_ff == ST_ADDR_ACK) || (state_ff == ST_REG_ACK) ||
            (state_ff == ST_WDATA_ACK) ||
            (state_ff == ST_RDATA && !tx_ff[7]);
      end
   end
   assign sda_o = 1'b0;

   // ************************************************************
   // register file and write effects
   // ************************************************************
   // unmapped offsets read as zero
   always_comb begin
      case (ptr_ff)
         OFS_FAST_MODE: rd_value = regs_ff[CH_FAST];
         OFS_SIDE_MODE: rd_value = regs_ff[CH_SIDE];
         OFS_RX_SET: rd_value = regs_ff[CH_RX];
         OFS_TERM_PULSE: rd_value = regs_ff[CH_TERM];
         default: rd_value = 8'h00;
      endcase
   end

   // illegal mode code keeps the previous mode field
   always_comb begin
      merged = rx_ff;
      if (rx_ff[MODE_MSB:MODE_LSB] == MODE_BAD) begin
         merged[MODE_MSB:MODE_LSB] = rd_value[MODE_MSB:MODE_LSB];
      end
   end

   // write strobe fires on the scl fall that ends the last data bit
   always_comb begin
      wr_pulse = '0;
      wr_pulse[CH_FAST] = data_done && ptr_ff == OFS_FAST_MODE;
      wr_pulse[CH_SIDE] = data_done && ptr_ff == OFS_SIDE_MODE;
      wr_pulse[CH_RX] = data_done && ptr_ff == OFS_RX_SET;
      wr_pulse[CH_TERM] = data_done && ptr_ff == OFS_TERM_PULSE;
      wr_pulse[CH_PIN] = pin_change;
      wr_data[CH_FAST] = merged & MASK_MODE;
      wr_data[CH_SIDE] = merged & MASK_MODE;
      wr_data[CH_RX] = rx_ff & MASK_RX;
      wr_data[CH_TERM] = rx_ff & MASK_TERM;
      wr_data[CH_PIN] = pins_now;
   end

   // readable copy holds the newest written value of each register
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_CH; i++) begin
            regs_ff[i] <= CH_RST[i];
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (wr_pulse[i]) begin
               regs_ff[i] <= wr_data[i];
            end
         end
      end
   end

   // each register owns a window of its own length
   for (genvar g = 0; g < NUM_CH; g++) begin : g_win
      update_window #(
         .RST_VAL(CH_RST[g]),
         .DLY(16'(DLY_CYC[g]))
      ) u_win (
         .clock_i(clock_i),
         .rst_i(rst_i),
         .wr_i(wr_pulse[g]),
         .wr_data_i(wr_data[g]),
         .applied_o(applied[g])
      );
   end

   // ************************************************************
   // pin control path and serial takeover
   // ************************************************************
   assign pins_now = {pin_ctl_out_current_i, pin_ctl_out_term_i,
      pin_ctl_emphasis_i, pin_ctl_equalize_i, pin_ctl_source_i, pin_ctl_on_i};
   // first cycle after reset loads the pins, later only changes count
   assign pin_change = !serial_mode_ff &&
      (!pins_primed_ff || pins_now != pins_ff);

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pins_ff <= 8'h00;
         pins_primed_ff <= 1'b0;
      end else begin
         pins_ff <= pins_now;
         pins_primed_ff <= 1'b1;
      end
   end

   // an acked own address is the first serial event; sticky until reset
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         serial_mode_ff <= 1'b0;
      end else if (state_ff == ST_ADDR && last_bit && addr_hit) begin
         serial_mode_ff <= 1'b1;
      end
   end
   assign serial_mode_o = serial_mode_ff;

   // pin mode forces quad bundling and the same source on both switches
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         fast_switch_on_o <= RST_FAST_MODE[SW_ON_BIT];
         fast_bundle_mode_o <= MODE_QUAD;
         fast_source_sel_o <= 4'h0;
         side_switch_on_o <= RST_SIDE_MODE[SW_ON_BIT];
         side_bundle_mode_o <= MODE_QUAD;
         side_source_sel_o <= 4'h0;
         input_term_sel_o <= RST_RX_SET[0];
         term_pulse_sel_o <= RST_TERM_PULSE;
         equalize_o <= SER_EQ;
         emphasis_o <= SER_PRE;
         out_term_o <= SER_OTO;
         out_current_o <= SER_OCL;
      end else if (serial_mode_ff) begin
         fast_switch_on_o <= applied[CH_FAST][SW_ON_BIT];
         fast_bundle_mode_o <= applied[CH_FAST][MODE_MSB:MODE_LSB];
         fast_source_sel_o <= applied[CH_FAST][SRC_MSB:0];
         side_switch_on_o <= applied[CH_SIDE][SW_ON_BIT];
         side_bundle_mode_o <= applied[CH_SIDE][MODE_MSB:MODE_LSB];
         side_source_sel_o <= applied[CH_SIDE][SRC_MSB:0];
         input_term_sel_o <= applied[CH_RX][0];
         term_pulse_sel_o <= applied[CH_TERM];
         equalize_o <= SER_EQ;
         emphasis_o <= SER_PRE;
         out_term_o <= SER_OTO;
         out_current_o <= SER_OCL;
      end else begin
         fast_switch_on_o <= applied[CH_PIN][PIN_ON];
         fast_bundle_mode_o <= MODE_QUAD;
         fast_source_sel_o <= {2'h0, applied[CH_PIN][PIN_SRC_LSB+:2]};
         side_switch_on_o <= applied[CH_PIN][PIN_ON];
         side_bundle_mode_o <= MODE_QUAD;
         side_source_sel_o <= {2'h0, applied[CH_PIN][PIN_SRC_LSB+:2]};
         input_term_sel_o <= PIN_RX_TERM;
         term_pulse_sel_o <= RST_TERM_PULSE;
         equalize_o <= applied[CH_PIN][PIN_EQ];
         emphasis_o <= applied[CH_PIN][PIN_PRE_LSB+:2];
         out_term_o <= applied[CH_PIN][PIN_OTO];
         out_current_o <= applied[CH_PIN][PIN_OCL];
      end
   end
   assign fast_standby_o = ~fast_switch_on_o;

   // ************************************************************
   // checks
   // ************************************************************
   addr_nack_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (state_ff == ST_ADDR && last_bit && !addr_hit && !start_seen)
      |=> state_ff == ST_IDLE ##1 !sda_oe_o)
      else $error("foreign address not ignored");
   addr_ack_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (state_ff == ST_ADDR && last_bit && addr_hit && !start_seen)
      |=> state_ff == ST_ADDR_ACK ##1 sda_oe_o)
      else $error("matching address not acknowledged");
   ptr_load_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (state_ff == ST_REG && last_bit && !start_seen)
      |=> ptr_ff == $past(rx_ff) && state_ff == ST_REG_ACK)
      else $error("register address not captured");
   rd_load_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (state_ff == ST_ADDR_ACK && scl_fall && rw_ff && !start_seen &&
       !stop_seen) |=> state_ff == ST_RDATA && tx_ff == $past(rd_value))
      else $error("read data not taken from pointed register");
   ptr_keep_a: assert property (@(posedge clock_i) disable iff (rst_i)
      start_seen |=> $stable(ptr_ff) && state_ff == ST_ADDR)
      else $error("pointer lost across a restart");
   takeover_a: assert property (@(posedge clock_i) disable iff (rst_i)
      serial_mode_ff |=> serial_mode_ff && !pin_change)
      else $error("pin control came back after serial access");
   mode_keep_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (wr_pulse[CH_FAST] && rx_ff[MODE_MSB:MODE_LSB] == MODE_BAD)
      |=> regs_ff[CH_FAST][MODE_MSB:MODE_LSB] ==
          $past(regs_ff[CH_FAST][MODE_MSB:MODE_LSB]))
      else $error("illegal mode code was stored");
   wr_strobe_a: assert property (@(posedge clock_i) disable iff (rst_i)
      (data_done && ptr_ff == OFS_SIDE_MODE) |-> wr_pulse[CH_SIDE]
      ##1 regs_ff[CH_SIDE] == ($past(merged) & MASK_MODE))
      else $error("write strobe missing at last data bit");
endmodule

// File: tb/i2c_master_model.sv
// serial bus master that drives the switch control port
// assumes the bench resolves the pulled-up sda line and feeds it back
`timescale 1ns/10ps
module i2c_master_model (
   input wire logic clock_i,
   input wire logic sda_line_i,
   output logic scl_o,
   output logic sda_o
);
   // half a serial period, well above the two clocks the slave needs
   localparam int HALF = 8;
   // ******
   // line primitives
   // ******
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   // also serves as repeated start: sda is raised while scl is low
   task automatic start();
      sda_o = 1'b1;
      tick(HALF);
      scl_o = 1'b1;
      tick(HALF);
      sda_o = 1'b0;
      tick(HALF);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      sda_o = 1'b0;
      tick(HALF);
      scl_o = 1'b1;
      tick(HALF);
      sda_o = 1'b1;
      tick(HALF);
   endtask
   // msb first, then release sda and sample the slave's acknowledge
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_o = b[i];
         tick(HALF);
         scl_o = 1'b1;
         tick(HALF);
         scl_o = 1'b0;
      end
      sda_o = 1'b1;
      tick(HALF);
      scl_o = 1'b1;
      tick(2);
      ack = ~sda_line_i;
      tick(HALF - 2);
      scl_o = 1'b0;
   endtask
   task automatic recv_byte(input logic ack_it, output logic [7:0] b);
      sda_o = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         tick(HALF);
         scl_o = 1'b1;
         tick(2);
         b[i] = sda_line_i;
         tick(HALF - 2);
         scl_o = 1'b0;
      end
      sda_o = ~ack_it;
      tick(HALF);
      scl_o = 1'b1;
      tick(HALF);
      scl_o = 1'b0;
   endtask
   // ******
   // whole transfers
   // ******
   task automatic xfer_write(input logic [6:0] dev, input logic [7:0] ofs,
      input logic [7:0] dat, output logic [2:0] acks);
      start();
      send_byte({dev, 1'b0}, acks[2]);
      send_byte(ofs, acks[1]);
      send_byte(dat, acks[0]);
      stop();
   endtask
   // first byte acked, second nacked so the slave frees sda for stop
   task automatic xfer_read(input logic [6:0] dev, input logic [7:0] ofs,
      input logic set_ptr, output logic [7:0] d0, output logic [7:0] d1,
      output logic [2:0] acks);
      acks = 3'h7;
      start();
      if (set_ptr) begin
         send_byte({dev, 1'b0}, acks[2]);
         send_byte(ofs, acks[1]);
         start();
      end
      send_byte({dev, 1'b1}, acks[0]);
      recv_byte(1'b1, d0);
      recv_byte(1'b0, d1);
      stop();
   endtask
endmodule

// File: tb/switch_control_serial_port_test.sv
// self-checking bench for the switch control serial port
// assumes the master model in tb and a pulled-up sda line
`timescale 1ns/10ps
module switch_control_serial_port_test;
   import switch_ctl_pkg::*;
   localparam logic [6:0] DEV = {DEV_ADDR_HI, 3'h5};
   logic clock_i, rst_i, scl, m_sda, d_sda, d_oe, ser, f_on, f_sb, s_on;
   logic t_sel, eq, ot, oc;
   logic [1:0] f_md, s_md, emph;
   logic [3:0] f_src, s_src;
   logic [7:0] pins, t_pls, d0, d1;
   logic [2:0] acks;
   logic [7:0] ofs_tab [5] = '{8'h00, 8'h01, 8'h10, 8'h20, 8'h11};
   // 0x10 is written with 0xfe, so only its masked low bit shows
   logic [7:0] exp_tab [5] = '{8'h63, 8'h1e, 8'h00, 8'h00, 8'ha5};
   int err_count = 0;
   int checks = 0;
   // wired-and of the master and the open drain slave
   wire sda = m_sda & ~(d_oe & ~d_sda);
   switch_control_serial_port switch_control_serial_port_inst (
      .clock_i(clock_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
      .sda_o(d_sda), .sda_oe_o(d_oe), .addr_strap_bit0_i(1'b1),
      .addr_strap_bit1_i(1'b0), .addr_strap_bit2_i(1'b1),
      .pin_ctl_on_i(pins[PIN_ON]), .pin_ctl_source_i(pins[PIN_SRC_LSB +: 2]),
      .pin_ctl_equalize_i(pins[PIN_EQ]),
      .pin_ctl_emphasis_i(pins[PIN_PRE_LSB +: 2]),
      .pin_ctl_out_term_i(pins[PIN_OTO]), .pin_ctl_out_current_i(pins[PIN_OCL]),
      .serial_mode_o(ser), .fast_switch_on_o(f_on), .fast_standby_o(f_sb),
      .fast_bundle_mode_o(f_md), .fast_source_sel_o(f_src),
      .side_switch_on_o(s_on), .side_bundle_mode_o(s_md),
      .side_source_sel_o(s_src), .input_term_sel_o(t_sel),
      .term_pulse_sel_o(t_pls), .equalize_o(eq), .emphasis_o(emph),
      .out_term_o(ot), .out_current_o(oc));
   i2c_master_model i2c_master_model_inst (.clock_i(clock_i),
      .sda_line_i(sda), .scl_o(scl), .sda_o(m_sda));
   // ******
   // helpers
   // ******
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] expv);
      checks++;
      if (seen !== expv) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, expv, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   // a hung handshake must not stall the run forever
   initial begin
      repeat (20000) @(posedge clock_i);
      err_count++;
      tally_and_finish();
   end
   // ******
   // tests
   // ******
   initial begin
      rst_i = 1'b1;
      pins = 8'h1d;
      cyc(6);
      rst_i = 1'b0;
      cyc(5);
      pins[PIN_EQ] = 1'b0;
      cyc(5);
      check("eq held", {7'h00, eq}, 8'h01);
      check("pin src", {2'h0, f_md, f_src}, 8'h02);
      check("pin emph", {4'h0, emph, ot, oc}, 8'h04);
      check("pin term", {7'h00, t_sel}, {7'h00, PIN_RX_TERM});
      cyc(DLY_CYC[CH_PIN] + 5);
      check("eq late", {7'h00, eq}, 8'h00);
      pins[PIN_PRE_LSB +: 2] = 2'h3;
      cyc(4);
      check("emph now", {6'h00, emph}, 8'h03);
      $display("test pin path done");
      i2c_master_model_inst.xfer_write(DEV ^ 7'h01, 8'h00, 8'h00, acks);
      check("foreign acks", {5'h00, acks}, 8'h00);
      check("pins rule", {7'h00, ser}, 8'h00);
      i2c_master_model_inst.xfer_write(DEV, OFS_FAST_MODE, 8'h25, acks);
      check("write acks", {5'h00, acks}, 8'h07);
      check("takeover", {5'h00, ser, emph}, 8'h04);
      check("rx default", {7'h00, t_sel}, {7'h00, RST_RX_SET[0]});
      check("standby", {6'h00, f_on, f_sb}, 8'h01);
      check("fast mode", {2'h0, f_md, f_src}, 8'h25);
      // a pin change after takeover must not reach the outputs
      pins[PIN_EQ] = 1'b1;
      i2c_master_model_inst.xfer_write(DEV, OFS_FAST_MODE, 8'h73, acks);
      i2c_master_model_inst.xfer_write(DEV, OFS_SIDE_MODE, 8'h1e, acks);
      i2c_master_model_inst.xfer_write(DEV, OFS_RX_SET, 8'hfe, acks);
      i2c_master_model_inst.xfer_write(DEV, OFS_TERM_PULSE, 8'ha5, acks);
      cyc(DLY_CYC[CH_TERM]);
      check("pins ignored", {7'h00, eq}, {7'h00, SER_EQ});
      check("bad mode", {1'b0, f_on, f_md, f_src}, 8'h63);
      check("side", {1'b0, s_on, s_md, s_src}, 8'h1e);
      check("rx term", {7'h00, t_sel}, 8'h00);
      check("pulse", t_pls, 8'ha5);
      $display("test serial write done");
      foreach (ofs_tab[i]) begin
         i2c_master_model_inst.xfer_read(DEV, ofs_tab[i], 1'b1, d0, d1, acks);
         check("read acks", {5'h00, acks}, 8'h07);
         check("read", d0, exp_tab[i]);
         check("read next", d1, exp_tab[i]);
      end
      i2c_master_model_inst.xfer_read(DEV, 8'h00, 1'b0, d0, d1, acks);
      check("kept pointer", d0, 8'ha5);
      $display("test readback done");
      tally_and_finish();
   end
endmodule
